/* File: rfmux_top.sv */
`timescale 1ns/1ns
`include "rfmux_regs.svh"
// quad 1x4 selector card controller
module rfmux_top
   import rfmux_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // card slot strap
   input wire logic [3:0] my_slot,
   // request from the command processor
   input wire logic req_valid,
   input wire logic [2:0] req_cmd,
   input wire logic [3:0] req_slot,
   input wire logic [3:0] req_bank,
   input wire logic [3:0] req_input,
   output logic req_ready,
   // answer
   output logic rsp_valid_q,
   output logic rsp_err_q,
   output logic rsp_closed_q,
   output logic [`RFMUX_CNT_W-1:0] rsp_count_q,
   // relay coils: index bank*3 + relay
   output logic [11:0] coil_set,
   output logic [11:0] coil_rst
);
   logic rst_meta_q;
   logic rst_n_q;
   rfmux_state_e state_q;
   logic [1:0] sel_q [`RFMUX_NBANK];
   logic [1:0] tbank_q;
   logic [1:0] tsel_q;
   logic [`RFMUX_NBANK-1:0] clr;
   logic [2:0] mreq [`RFMUX_NBANK];
   logic [2:0] mdir [`RFMUX_NBANK];
   logic [2:0] pos [`RFMUX_NBANK];
   logic [`RFMUX_NBANK-1:0] busy;
   logic [`RFMUX_CNT_W-1:0] mcnt [`RFMUX_NBANK];
   logic addr_ok;
   logic take;
   logic [1:0] rb;
   logic [1:0] ri;
   logic [1:0] pon_ph_q;

   // reset release through two flops
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // channel 11..44: tens digit bank, units digit input
   assign rb = 2'(req_bank - 4'h1);
   assign ri = 2'(req_input - 4'h1);
   assign addr_ok = req_slot == my_slot && req_slot >= `RFMUX_SLOT_MIN && req_slot <= `RFMUX_SLOT_MAX
      && req_bank >= 4'h1 && req_bank <= 4'h4 && req_input >= 4'h1 && req_input <= 4'h4;
   // requests are held off while a relay sequence runs
   assign req_ready = rst_n_q && (state_q == RFMUX_IDLE);
   assign take = req_valid && req_ready;

   // sequencer: set the new leaf first, then swing the tree onto its half
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= RFMUX_IDLE;
         tbank_q <= 2'h0;
         tsel_q <= 2'h0;
         pon_ph_q <= 2'h0;
      end else begin
         case (state_q)
            RFMUX_IDLE: begin
               if (take && addr_ok && req_cmd == `RFMUX_CMD_CLOSE) begin
                  tbank_q <= rb;
                  tsel_q <= ri;
                  state_q <= RFMUX_BREAK;
               end else if (take && req_slot == my_slot && req_cmd == `RFMUX_CMD_PON) begin
                  pon_ph_q <= 2'h0;
                  state_q <= RFMUX_PON;
               end
            end
            // new leaf settles first, while the tree points away unless old and new share a half, so only old or new input reaches the common
            RFMUX_BREAK: if (!busy[tbank_q]) state_q <= RFMUX_MAKE;
            RFMUX_MAKE: if (!busy[tbank_q]) state_q <= RFMUX_DONE;
            // power-on walks leaf a, then the tree, then leaf b, one group at a time
            RFMUX_PON: begin
               if (busy == '0) begin
                  if (pon_ph_q == 2'h2) state_q <= RFMUX_DONE;
                  else pon_ph_q <= pon_ph_q + 2'h1;
               end
            end
            RFMUX_DONE: if (busy == '0) state_q <= RFMUX_IDLE;
            default: state_q <= RFMUX_IDLE;
         endcase
      end
   end

   // relay move requests per bank, issued on state entry
   always_comb begin
      for (int b = 0; b < `RFMUX_NBANK; b++) begin
         mreq[b] = 3'h0;
         mdir[b] = 3'h0;
         clr[b] = 1'b0;
      end
      if (take && addr_ok && req_cmd == `RFMUX_CMD_CNTCLR) clr[rb] = 1'b1;
      if (take && addr_ok && req_cmd == `RFMUX_CMD_CLOSE) begin
         // leaf on the selected half picks the input; the tree may still show the other half
         mreq[rb][ri[1]] = 1'b1;
         mdir[rb][ri[1]] = ri[0];
      end
      if (state_q == RFMUX_BREAK && !busy[tbank_q]) begin
         // tree last: the common sees the new input only once its leaf has settled
         mreq[tbank_q][RFMUX_TREE] = 1'b1;
         mdir[tbank_q][RFMUX_TREE] = tsel_q[1];
      end
      if (take && req_slot == my_slot && req_cmd == `RFMUX_CMD_PON) begin
         for (int b = 0; b < `RFMUX_NBANK; b++) mreq[b][RFMUX_LEAF_A] = 1'b1;
      end
      // later power-on steps: tree home onto leaf a, then the isolated leaf b home
      if (state_q == RFMUX_PON && busy == '0 && pon_ph_q != 2'h2) begin
         for (int b = 0; b < `RFMUX_NBANK; b++) begin
            if (pon_ph_q == 2'h0) mreq[b][RFMUX_TREE] = 1'b1;
            else mreq[b][RFMUX_LEAF_B] = 1'b1;
         end
      end
   end

   // selected input per bank; one per bank, a new close replaces it
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         for (int b = 0; b < `RFMUX_NBANK; b++) sel_q[b] <= `RFMUX_POWERON_SEL;
      end else if (take && addr_ok && req_cmd == `RFMUX_CMD_CLOSE) begin
         sel_q[rb] <= ri;
      end else if (take && req_slot == my_slot && req_cmd == `RFMUX_CMD_PON) begin
         for (int b = 0; b < `RFMUX_NBANK; b++) sel_q[b] <= `RFMUX_POWERON_SEL;
      end
   end

   // answers: one pulse per accepted request
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rsp_valid_q <= 1'b0;
         rsp_err_q <= 1'b0;
         rsp_closed_q <= 1'b0;
         rsp_count_q <= '0;
      end else begin
         rsp_valid_q <= take;
         // unknown commands, open requests included, are refused
         rsp_err_q <= take && (!addr_ok && req_cmd != `RFMUX_CMD_PON
            || req_cmd == 3'h0 || req_cmd > `RFMUX_CMD_PON || req_slot != my_slot);
         rsp_closed_q <= take && req_cmd == `RFMUX_CMD_QUERY && addr_ok && sel_q[rb] == ri;
         rsp_count_q <= (take && req_cmd == `RFMUX_CMD_CNTRD && addr_ok) ? mcnt[rb] : '0;
      end
   end

   genvar g;
   for (g = 0; g < `RFMUX_NBANK; g++) begin : g_bank
      rfmux_bank u_bank (
         .core_clk(core_clk),
         .rst_n(rst_n_q),
         .move_req(mreq[g]),
         .move_dir(mdir[g]),
         .cnt_clr(clr[g]),
         .pos_q(pos[g]),
         .coil_set_q(coil_set[g*3 +: 3]),
         .coil_rst_q(coil_rst[g*3 +: 3]),
         .busy(busy[g]),
         .max_cnt(mcnt[g])
      );
   end

   a_query_closed: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      take && req_cmd == `RFMUX_CMD_QUERY && addr_ok && sel_q[rb] == ri |=> rsp_closed_q)
      else $error("query misses closed channel");
   a_break_first: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      state_q == RFMUX_MAKE |-> pos[tbank_q][tsel_q[1]] == tsel_q[0]) else $error("tree moved before leaf");
   a_close_sets: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      take && addr_ok && req_cmd == `RFMUX_CMD_CLOSE |=> sel_q[$past(rb)] == $past(ri))
      else $error("close not recorded");
   a_count_read: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      take && req_cmd == `RFMUX_CMD_CNTRD && addr_ok |=> rsp_count_q == $past(mcnt[rb]))
      else $error("count read wrong");
   a_pon_home: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      take && req_slot == my_slot && req_cmd == `RFMUX_CMD_PON |=> sel_q[0] == `RFMUX_POWERON_SEL)
      else $error("power-on not restored");
   a_bad_slot: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      take && req_slot != my_slot |=> rsp_err_q) else $error("foreign slot accepted");
endmodule : rfmux_top

/* File: rfmux_regs.svh */
`ifndef RFMUX_REGS_SVH
`define RFMUX_REGS_SVH
`define RFMUX_NBANK 4
`define RFMUX_CNT_W 32
`define RFMUX_SLOT_MIN 4'h1
`define RFMUX_SLOT_MAX 4'h8
`define RFMUX_PULSE_NS 10000
`define RFMUX_CLK_NS 10
`define RFMUX_PULSE_CYC ((`RFMUX_PULSE_NS + `RFMUX_CLK_NS - 1) / `RFMUX_CLK_NS)
`define RFMUX_TMR_W 16
`define RFMUX_POWERON_SEL 2'h0
`define RFMUX_CMD_CLOSE 3'h1
`define RFMUX_CMD_QUERY 3'h2
`define RFMUX_CMD_CNTRD 3'h3
`define RFMUX_CMD_CNTCLR 3'h4
`define RFMUX_CMD_PON 3'h5
`endif

/* File: rfmux_pkg.sv */
package rfmux_pkg;
   // relay indices within a bank: two leaves then the tree
   typedef enum logic [1:0] {
      RFMUX_LEAF_A = 2'h0,
      RFMUX_LEAF_B = 2'h1,
      RFMUX_TREE = 2'h2
   } rfmux_relay_e;
   // one-hot sequencer states
   typedef enum logic [4:0] {
      RFMUX_IDLE = 5'h01,
      RFMUX_BREAK = 5'h02,
      RFMUX_MAKE = 5'h04,
      RFMUX_PON = 5'h08,
      RFMUX_DONE = 5'h10
   } rfmux_state_e;
endpackage : rfmux_pkg

/* File: rfmux_bank.sv */
`timescale 1ns/1ns
`include "rfmux_regs.svh"
// one bank: three latching relays driven by set/reset coil pulses
module rfmux_bank
   import rfmux_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // relay move request, one pulse per move
   input wire logic [2:0] move_req,
   input wire logic [2:0] move_dir,
   // counter clear
   input wire logic cnt_clr,
   // relay positions and coils
   output logic [2:0] pos_q,
   output logic [2:0] coil_set_q,
   output logic [2:0] coil_rst_q,
   output logic busy,
   // largest counter of the bank
   output logic [`RFMUX_CNT_W-1:0] max_cnt
);
   logic [`RFMUX_TMR_W-1:0] tmr_q;
   logic [`RFMUX_CNT_W-1:0] cnt_q [3];
   logic [`RFMUX_CNT_W-1:0] m01;
   logic [2:0] pend_q;

   assign busy = (tmr_q != '0);

   // coil pulse timer; latching relays need no drive after it ends
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tmr_q <= '0;
         pend_q <= 3'h0;
      end else if (move_req != 3'h0) begin
         tmr_q <= `RFMUX_TMR_W'(`RFMUX_PULSE_CYC);
         pend_q <= move_req;
      end else if (busy) begin
         tmr_q <= tmr_q - 1'b1;
      end
   end

   genvar i;
   for (i = 0; i < 3; i++) begin : g_relay
      // coil drive and position of one latching relay
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            coil_set_q[i] <= 1'b0;
            coil_rst_q[i] <= 1'b0;
            pos_q[i] <= 1'b0;
         end else if (move_req[i] && move_dir[i] != pos_q[i]) begin
            coil_set_q[i] <= move_dir[i];
            coil_rst_q[i] <= !move_dir[i];
         end else if (tmr_q == `RFMUX_TMR_W'(1) && pend_q[i]) begin
            coil_set_q[i] <= 1'b0;
            coil_rst_q[i] <= 1'b0;
            if (coil_set_q[i] || coil_rst_q[i]) pos_q[i] <= coil_set_q[i];
         end
      end
      // counter bumps when the pulse completes an actual move
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            cnt_q[i] <= '0;
         end else if (cnt_clr) begin
            cnt_q[i] <= '0;
         end else if (tmr_q == `RFMUX_TMR_W'(1) && pend_q[i] && (coil_set_q[i] || coil_rst_q[i])) begin
            cnt_q[i] <= cnt_q[i] + 1'b1;
         end
      end
   end

   // bank figure is the largest of the three
   assign m01 = (cnt_q[0] > cnt_q[1]) ? cnt_q[0] : cnt_q[1];
   assign max_cnt = (m01 > cnt_q[2]) ? m01 : cnt_q[2];

   a_count_on_move: assert property (@(posedge core_clk) disable iff (!rst_n)
      (tmr_q == `RFMUX_TMR_W'(1) && pend_q[0] && coil_set_q[0] && !cnt_clr)
      |=> cnt_q[0] == $past(cnt_q[0]) + 1'b1) else $error("leaf count missed");
   a_clear_bank: assert property (@(posedge core_clk) disable iff (!rst_n)
      cnt_clr |=> max_cnt == '0) else $error("bank clear failed");
endmodule : rfmux_bank

/* File: rfmux_host.sv */
`timescale 1ns/1ns
`include "rfmux_regs.svh"
// command processor model: one request at a time
module rfmux_host
   import rfmux_pkg::*;
(
   // clock
   input wire logic core_clk,
   // request
   output logic req_valid,
   output logic [2:0] req_cmd,
   output logic [3:0] req_slot,
   output logic [3:0] req_bank,
   output logic [3:0] req_input,
   input wire logic req_ready,
   // answer
   input wire logic rsp_valid_q,
   input wire logic rsp_err_q,
   input wire logic rsp_closed_q,
   input wire logic [`RFMUX_CNT_W-1:0] rsp_count_q
);
   initial begin
      req_valid = 1'b0;
      req_cmd = 3'h0;
      req_slot = 4'h0;
      req_bank = 4'h0;
      req_input = 4'h0;
   end
   // called just after a rising edge; only close, query, count and power-on codes exist
   task send(input logic [2:0] c, input logic [3:0] s, b, i, output logic e, cl,
             output logic [`RFMUX_CNT_W-1:0] n);
      int k;
      req_valid <= 1'b1;
      req_cmd <= c;
      req_slot <= s;
      req_bank <= b;
      req_input <= i;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (req_ready !== 1'b1 && k < 6000);
      // released fields turn over so stale values never look valid
      req_valid <= 1'b0;
      req_cmd <= ~c;
      req_slot <= ~s;
      req_bank <= ~b;
      req_input <= ~i;
      k = 0;
      do begin
         @(negedge core_clk);
         k++;
      end while (rsp_valid_q !== 1'b1 && k < 4);
      e = rsp_valid_q ? rsp_err_q : 1'bx;
      // a missing answer leaves unknowns, so every check on it fails
      cl = rsp_valid_q ? rsp_closed_q : 1'bx;
      n = rsp_valid_q ? rsp_count_q : 'x;
      @(posedge core_clk);
   endtask : send
endmodule : rfmux_host

/* File: tb_top.sv */
`timescale 1ns/1ns
`include "rfmux_regs.svh"
module tb_top;
   import rfmux_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] my_slot = 4'h5;
   logic req_valid, req_ready, rsp_valid_q, rsp_err_q, rsp_closed_q, err, cl;
   logic [2:0] req_cmd;
   logic [3:0] req_slot, req_bank, req_input;
   logic [`RFMUX_CNT_W-1:0] rsp_count_q, cnt;
   logic [11:0] coil_set, coil_rst;
   logic [11:0] pos = 12'h000;
   logic [23:0] pv = 24'h000000;
   int fails = 0, n_tests = 0, run = 0, bk = 0, ok_a = 1, ok_b = 1;
   int sel[5] = '{1, 1, 1, 1, 1};
   logic [14:0] bad[7] = '{{3'h2, 4'h6, 4'h1, 4'h1}, {3'h2, 4'h5, 4'h0, 4'h1}, {3'h1, 4'h5, 4'h5, 4'h1},
      {3'h2, 4'h5, 4'h1, 4'h5}, {3'h0, 4'h5, 4'h1, 4'h1}, {3'h6, 4'h5, 4'h1, 4'h1}, {3'h7, 4'h5, 4'h1, 4'h1}};
   initial forever #5 core_clk = ~core_clk;
   rfmux_top dut (.core_clk(core_clk), .reset_n(reset_n), .my_slot(my_slot), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_slot(req_slot), .req_bank(req_bank), .req_input(req_input),
      .req_ready(req_ready), .rsp_valid_q(rsp_valid_q), .rsp_err_q(rsp_err_q),
      .rsp_closed_q(rsp_closed_q), .rsp_count_q(rsp_count_q), .coil_set(coil_set), .coil_rst(coil_rst));
   rfmux_host host (.core_clk(core_clk), .req_valid(req_valid), .req_cmd(req_cmd), .req_slot(req_slot),
      .req_bank(req_bank), .req_input(req_input), .req_ready(req_ready), .rsp_valid_q(rsp_valid_q),
      .rsp_err_q(rsp_err_q), .rsp_closed_q(rsp_closed_q), .rsp_count_q(rsp_count_q));
   task chk(input string what, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk
   task rq(input logic [2:0] c, input logic [3:0] b, i);
      host.send(c, my_slot, b, i, err, cl, cnt);
   endtask : rq
   // move a bank; the watcher accepts only the old or new input on the common
   task close(input int b, i);
      bk = b;
      ok_a = sel[b];
      ok_b = i;
      rq(`RFMUX_CMD_CLOSE, b[3:0], i[3:0]);
      chk("close err", 32'(err), 32'h0);
      sel[b] = i;
   endtask : close
   // coil watcher, one cycle late but consistent: pulse width, one coil at a time
   always @(posedge core_clk) begin
      logic [23:0] v;
      int t, tr, lf;
      v = {coil_set, coil_rst};
      if (v != pv) begin
         if (pv != 24'h000000) chk("pulse width", run, `RFMUX_PULSE_CYC);
         chk("coils at once", 32'($countones(v) <= 1), 32'h1);
         pos = (pos | coil_set) & ~coil_rst;
         t = bk * 3 - 3;
         if (bk != 0) begin
            tr = pos[t + 2];
            lf = tr ? pos[t + 1] : pos[t];
            chk("common input", 32'((tr * 2 + lf + 1) inside {ok_a, ok_b}), 32'h1);
         end
         run = 1;
      end else run = run + 1;
      pv = v;
   end
   task t_close;
      close(1, 4);
      rq(`RFMUX_CMD_QUERY, 4'h1, 4'h4);
      chk("query 14", 32'(cl), 32'h1);
      rq(`RFMUX_CMD_QUERY, 4'h1, 4'h1);
      chk("query 11", 32'(cl), 32'h0);
      rq(`RFMUX_CMD_CNTRD, 4'h1, 4'h2);
      chk("count 12", cnt, 32'h1);
      close(1, 3);
      close(1, 3);
      rq(`RFMUX_CMD_CNTRD, 4'h1, 4'h1);
      chk("count 11", cnt, 32'h2);
      rq(`RFMUX_CMD_QUERY, 4'h1, 4'h3);
      chk("query 13", 32'(cl), 32'h1);
      $display("test close done");
   endtask : t_close
   // other banks untouched, then bank 4 moves on its own
   task t_banks;
      for (int b = 2; b <= 4; b++) begin
         rq(`RFMUX_CMD_QUERY, b[3:0], 4'h1);
         chk("query x1", 32'(cl), 32'h1);
         rq(`RFMUX_CMD_CNTRD, b[3:0], 4'h3);
         chk("count x3", cnt, 32'h0);
      end
      close(4, 2);
      rq(`RFMUX_CMD_CNTRD, 4'h4, 4'h4);
      chk("count 44", cnt, 32'h1);
      rq(`RFMUX_CMD_CNTRD, 4'h1, 4'h4);
      chk("count 14", cnt, 32'h2);
      $display("test banks done");
   endtask : t_banks
   task t_clear;
      rq(`RFMUX_CMD_CNTCLR, 4'h1, 4'h2);
      rq(`RFMUX_CMD_CNTRD, 4'h1, 4'h4);
      chk("cleared 14", cnt, 32'h0);
      rq(`RFMUX_CMD_CNTRD, 4'h4, 4'h1);
      chk("kept 41", cnt, 32'h1);
      $display("test clear done");
   endtask : t_clear
   // wrong slot, bank, input and unknown codes are all refused
   task t_errors;
      for (int k = 0; k < 7; k++) begin
         host.send(bad[k][14:12], bad[k][11:8], bad[k][7:4], bad[k][3:0], err, cl, cnt);
         chk("refused", 32'(err), 32'h1);
      end
      $display("test errors done");
   endtask : t_errors
   task t_pon;
      bk = 0;
      rq(`RFMUX_CMD_PON, 4'h1, 4'h1);
      for (int b = 1; b <= 4; b++) begin
         rq(`RFMUX_CMD_QUERY, b[3:0], 4'h1);
         chk("pon x1", 32'(cl), 32'h1);
      end
      rq(`RFMUX_CMD_QUERY, 4'h1, 4'h3);
      chk("pon 13", 32'(cl), 32'h0);
      chk("pon relays", 32'(pos), 32'h0);
      $display("test power-on done");
   endtask : t_pon
   task finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   initial begin
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rq(`RFMUX_CMD_QUERY, 4'h1, 4'h1);
      chk("reset 11", 32'(cl), 32'h1);
      t_close();
      t_banks();
      t_clear();
      t_errors();
      t_pon();
      finish_test();
   end
   // watchdog: about five times the expected relay sequence time
   initial begin
      #600000;
      fails++;
      finish_test();
   end
endmodule : tb_top
